//--- bftie_pkg.sv
package bftie_pkg;

  // ----------------------------------------------------------------
  // widths and register file layout
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned REG_COUNT = 32;
  localparam logic [4:0]  PTR_X     = 5'h1a;
  localparam logic [4:0]  PTR_Y     = 5'h1c;
  localparam logic [4:0]  PTR_Z     = 5'h1e;

  // ----------------------------------------------------------------
  // status flag positions
  // ----------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ----------------------------------------------------------------
  // bus register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_FLAGS    = 8'h04;
  localparam logic [7:0]  ADR_SP       = 8'h08;
  localparam logic [7:0]  ADR_STATE    = 8'h0c;
  localparam logic [7:0]  ADR_GPR_BASE = 8'h80;
  localparam int unsigned CTRL_RUN     = 0;
  localparam logic        RUN_RESET    = 1'b0;
  localparam logic [7:0]  FLAGS_RESET  = 8'h00;
  localparam logic [15:0] SP_RESET     = 16'h01ff;

  // ----------------------------------------------------------------
  // execution timing in core cycles
  // ----------------------------------------------------------------
  localparam int unsigned CYC_SINGLE = 1;
  localparam int unsigned CYC_MEM    = 2;
  localparam int unsigned CYC_PMREAD = 3;

  typedef enum logic [4:0] {
    OP_NOP, OP_FLAG_SET, OP_FLAG_CLR, OP_BIT_TO_FLAG, OP_FLAG_TO_BIT,
    OP_REG_COPY, OP_PAIR_COPY, OP_LOAD_IMM, OP_SWAP, OP_IO_IN, OP_IO_OUT,
    OP_LOAD, OP_STORE, OP_PM_READ, OP_PM_READ_R0, OP_PM_WRITE,
    OP_PUSH, OP_POP, OP_SLEEP, OP_WDR, OP_BREAK
  } bftie_op_t;

  typedef enum logic [2:0] {
    AM_PLAIN, AM_POST_INC, AM_PRE_DEC, AM_DISP, AM_DIRECT, AM_POST_DEC, AM_PRE_INC
  } bftie_amode_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_MEM, ST_PM_WAIT, ST_PM_DATA, ST_PM_WRITE
  } bftie_state_t;

  function automatic logic [15:0] ptr_step(input logic [15:0] v, input logic up);
    ptr_step = up ? v + 16'h0001 : v - 16'h0001;
  endfunction : ptr_step

  function automatic logic [4:0] ptr_index(input logic [1:0] sel);
    ptr_index = (sel == 2'h0) ? PTR_X : (sel == 2'h1) ? PTR_Y : PTR_Z;
  endfunction : ptr_index

  function automatic logic is_single(input bftie_op_t op);
    is_single = !(op inside {OP_LOAD, OP_STORE, OP_PUSH, OP_POP,
                             OP_PM_READ, OP_PM_READ_R0, OP_PM_WRITE});
  endfunction : is_single

endpackage : bftie_pkg

//--- bftie_agu_if.sv
`timescale 1ns/10ps
interface bftie_agu_if;
  logic [15:0]             ptr;
  logic [15:0]             imm;
  bftie_pkg::bftie_amode_t mode;
  logic [15:0]             eff_addr;
  logic [15:0]             new_ptr;

  modport core (output ptr, output imm, output mode, input eff_addr, input new_ptr);
  modport agu  (input ptr, input imm, input mode, output eff_addr, output new_ptr);
endinterface : bftie_agu_if

//--- bftie_agu.sv
`timescale 1ns/10ps
module bftie_agu (
  bftie_agu_if.agu a
);
  // ----------------------------------------------------------------
  // effective address and pointer write-back
  // ----------------------------------------------------------------
  always_comb
  begin
    a.eff_addr = a.ptr;
    a.new_ptr  = a.ptr;
    case (a.mode)
      bftie_pkg::AM_POST_INC:
      begin
        a.new_ptr = bftie_pkg::ptr_step(a.ptr, 1'b1);
      end
      bftie_pkg::AM_PRE_DEC:
      begin
        a.new_ptr  = bftie_pkg::ptr_step(a.ptr, 1'b0);
        a.eff_addr = a.new_ptr;
      end
      bftie_pkg::AM_DISP:     a.eff_addr = a.ptr + {10'h000, a.imm[5:0]};
      bftie_pkg::AM_DIRECT:   a.eff_addr = a.imm;
      // the stack grows downward: push stores then steps, pop steps then reads
      bftie_pkg::AM_POST_DEC: a.new_ptr = bftie_pkg::ptr_step(a.ptr, 1'b0);
      bftie_pkg::AM_PRE_INC:
      begin
        a.new_ptr  = bftie_pkg::ptr_step(a.ptr, 1'b1);
        a.eff_addr = a.new_ptr;
      end
      default:
      begin
        a.eff_addr = a.ptr;
        a.new_ptr  = a.ptr;
      end
    endcase
  end
endmodule : bftie_agu

//--- bftie_core.sv
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
// What this block does
// [RQ1] flag set writes one, one cycle
// [RQ2] flag clear writes zero, one cycle
// [RQ3] register bit copied into transfer flag
// [RQ4] transfer flag copied into register bit
// [RQ5] load reads pointer, then increments it
// [RQ6] load decrements pointer, then reads
// [RQ7] load at pointer plus offset, pointer kept
// [RQ8] direct load from instruction address, two cycles
// [RQ9] store at pointer, then increments it
// [RQ10] store decrements pointer, then writes
// [RQ11] store at pointer plus offset, two cycles
// [RQ12] direct store to instruction address, two cycles
// [RQ13] program byte read via third pointer, three cycles
// [RQ14] push register onto stack, two cycles
// [RQ15] pop stack byte into register, two cycles
// [RQ16] sleep issues in one cycle, flags kept
// [RQ17] watchdog restart in one cycle, flags kept
// [RQ18] simple moves and no-op take one cycle
// [RQ19] program write stores r1:r0 at third pointer
// [RQ20] break acts only with debug enabled
module bftie_core (
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_wb_cyc,
  input  wire logic                 i_wb_stb,
  input  wire logic                 i_wb_we,
  input  wire logic [7:0]           i_wb_adr,
  input  wire logic [31:0]          i_wb_dat,
  input  wire logic [3:0]           i_wb_sel,
  output logic      [31:0]          o_wb_dat,
  output logic                      o_wb_ack,
  input  wire logic                 i_instr_valid,
  input  wire bftie_pkg::bftie_op_t i_instr_op,
  input  wire bftie_pkg::bftie_amode_t i_instr_mode,
  input  wire logic [1:0]           i_instr_ptr,
  input  wire logic [4:0]           i_instr_rd,
  input  wire logic [4:0]           i_instr_rr,
  input  wire logic [2:0]           i_instr_bit,
  input  wire logic [15:0]          i_instr_imm,
  output logic                      o_instr_ready,
  output logic                      o_instr_done,
  output logic      [15:0]          o_dm_addr,
  output logic      [7:0]           o_dm_wdata,
  output logic                      o_dm_we,
  output logic                      o_dm_re,
  input  wire logic [7:0]           i_dm_rdata,
  output logic      [15:0]          o_pm_addr,
  output logic                      o_pm_re,
  input  wire logic [7:0]           i_pm_rdata,
  output logic      [15:0]          o_pm_wdata,
  output logic                      o_pm_we,
  input  wire logic                 i_pm_wr_done,
  output logic      [5:0]           o_io_addr,
  output logic      [7:0]           o_io_wdata,
  output logic                      o_io_we,
  output logic                      o_io_re,
  input  wire logic [7:0]           i_io_rdata,
  input  wire logic                 i_debug_en,
  output logic                      o_sleep,
  output logic                      o_wdt_restart,
  output logic                      o_break,
  output logic      [7:0]           o_flags
);

  // ----------------------------------------------------------------
  // architectural state
  // ----------------------------------------------------------------
  logic [7:0]              gpr [0:bftie_pkg::REG_COUNT-1];
  logic [15:0]             sp;
  logic                    run;
  bftie_pkg::bftie_state_t state;
  logic [4:0]              ld_dst;
  logic                    accept;
  logic                    stack_op;
  logic                    pm_op;
  logic [4:0]              pidx;
  logic [4:0]              pidx_hi;
  logic                    wb_req;
  logic                    wb_wr;
  logic                    gpr_hit;
  logic                    src_bit;

  bftie_agu_if agu_bus ();

  bftie_agu u_agu (
    .a (agu_bus.agu)
  );

  assign o_instr_ready = run && (state == bftie_pkg::ST_IDLE);
  assign accept        = i_instr_valid && o_instr_ready;
  assign stack_op      = i_instr_op inside {bftie_pkg::OP_PUSH, bftie_pkg::OP_POP};
  assign pm_op         = i_instr_op inside {bftie_pkg::OP_PM_READ, bftie_pkg::OP_PM_READ_R0,
                                            bftie_pkg::OP_PM_WRITE};
  // program memory always goes through the third pointer pair
  assign pidx          = pm_op ? bftie_pkg::PTR_Z : bftie_pkg::ptr_index(i_instr_ptr); // [RQ13]
  assign pidx_hi       = 5'(pidx + 5'h01);
  assign src_bit       = gpr[i_instr_rr][i_instr_bit];

  assign agu_bus.ptr  = stack_op ? sp : {gpr[pidx_hi], gpr[pidx]};
  assign agu_bus.imm  = i_instr_imm;
  assign agu_bus.mode = (i_instr_op == bftie_pkg::OP_PUSH) ? bftie_pkg::AM_POST_DEC :
                        (i_instr_op == bftie_pkg::OP_POP)  ? bftie_pkg::AM_PRE_INC  :
                        (i_instr_op == bftie_pkg::OP_PM_READ_R0) ? bftie_pkg::AM_PLAIN :
                        i_instr_mode;

  // port access completes inside the issuing cycle, so it is driven combinationally
  assign o_io_addr  = i_instr_imm[5:0];
  assign o_io_wdata = gpr[i_instr_rr];
  assign o_io_we    = accept && (i_instr_op == bftie_pkg::OP_IO_OUT); // [RQ18]
  assign o_io_re    = accept && (i_instr_op == bftie_pkg::OP_IO_IN);

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  assign wb_req  = i_wb_cyc && i_wb_stb;
  assign wb_wr   = wb_req && i_wb_we && o_wb_ack;
  assign gpr_hit = i_wb_adr[7];

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= wb_req && !o_wb_ack;
      if (gpr_hit)
        o_wb_dat <= {24'h00_0000, gpr[i_wb_adr[6:2]]};
      else if (i_wb_adr == bftie_pkg::ADR_CTRL)
        o_wb_dat <= {31'h0000_0000, run};
      else if (i_wb_adr == bftie_pkg::ADR_FLAGS)
        o_wb_dat <= {24'h00_0000, o_flags};
      else if (i_wb_adr == bftie_pkg::ADR_SP)
        o_wb_dat <= {16'h0000, sp};
      else if (i_wb_adr == bftie_pkg::ADR_STATE)
        o_wb_dat <= {28'h000_0000, o_instr_ready, state};
      else
        o_wb_dat <= 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      run <= bftie_pkg::RUN_RESET;
    else if (wb_wr && i_wb_sel[0] && (i_wb_adr == bftie_pkg::ADR_CTRL))
      run <= i_wb_dat[bftie_pkg::CTRL_RUN];
  end

  // ----------------------------------------------------------------
  // status register: execution wins over a bus write in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_flags <= bftie_pkg::FLAGS_RESET;
    else if (accept && (i_instr_op == bftie_pkg::OP_FLAG_SET))
      o_flags[i_instr_bit] <= 1'b1;                    // [RQ1]
    else if (accept && (i_instr_op == bftie_pkg::OP_FLAG_CLR))
      o_flags[i_instr_bit] <= 1'b0;                    // [RQ2]
    else if (accept && (i_instr_op == bftie_pkg::OP_BIT_TO_FLAG))
      o_flags[bftie_pkg::FLAG_T] <= src_bit;           // [RQ3]
    else if (wb_wr && i_wb_sel[0] && (i_wb_adr == bftie_pkg::ADR_FLAGS))
      o_flags <= i_wb_dat[7:0];
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      sp <= bftie_pkg::SP_RESET;
    else if (accept && stack_op)
      sp <= agu_bus.new_ptr;                           // [RQ14] [RQ15]
    else if (wb_wr && (i_wb_adr == bftie_pkg::ADR_SP) && (i_wb_sel[1:0] == 2'h3))
      sp <= i_wb_dat[15:0];
  end

  // ----------------------------------------------------------------
  // working registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int i = 0; i < bftie_pkg::REG_COUNT; i++)
        gpr[i] <= 8'h00;
    end
    else
    begin
      if (wb_wr && gpr_hit && i_wb_sel[0])
        gpr[i_wb_adr[6:2]] <= i_wb_dat[7:0];
      if (accept)
      begin
        case (i_instr_op)
          bftie_pkg::OP_FLAG_TO_BIT: gpr[i_instr_rd][i_instr_bit] <= o_flags[bftie_pkg::FLAG_T]; // [RQ4]
          bftie_pkg::OP_REG_COPY:    gpr[i_instr_rd] <= gpr[i_instr_rr];                  // [RQ18]
          bftie_pkg::OP_PAIR_COPY:
          begin
            gpr[{i_instr_rd[4:1], 1'b0}] <= gpr[{i_instr_rr[4:1], 1'b0}];
            gpr[{i_instr_rd[4:1], 1'b1}] <= gpr[{i_instr_rr[4:1], 1'b1}];
          end
          bftie_pkg::OP_LOAD_IMM:    gpr[i_instr_rd] <= i_instr_imm[7:0];
          bftie_pkg::OP_SWAP:        gpr[i_instr_rd] <= {gpr[i_instr_rd][3:0], gpr[i_instr_rd][7:4]};
          bftie_pkg::OP_IO_IN:       gpr[i_instr_rd] <= i_io_rdata;
          // pointer steps at issue; displacement and direct modes leave it as is
          bftie_pkg::OP_LOAD, bftie_pkg::OP_STORE, bftie_pkg::OP_PM_READ:
            {gpr[pidx_hi], gpr[pidx]} <= agu_bus.new_ptr;      // [RQ5] [RQ6] [RQ9] [RQ10]
          default:
          begin
          end
        endcase
      end
      if (state == bftie_pkg::ST_MEM && o_dm_re)
        gpr[ld_dst] <= i_dm_rdata;                             // [RQ7] [RQ8] [RQ15]
      if (state == bftie_pkg::ST_PM_DATA)
        gpr[ld_dst] <= i_pm_rdata;                             // [RQ13]
    end
  end

  // ----------------------------------------------------------------
  // sequencer for multi-cycle work and control pulses
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state         <= bftie_pkg::ST_IDLE;
      ld_dst        <= 5'h00;
      o_instr_done  <= 1'b0;
      o_dm_addr     <= 16'h0000;
      o_dm_wdata    <= 8'h00;
      o_dm_we       <= 1'b0;
      o_dm_re       <= 1'b0;
      o_pm_addr     <= 16'h0000;
      o_pm_re       <= 1'b0;
      o_pm_wdata    <= 16'h0000;
      o_pm_we       <= 1'b0;
      o_sleep       <= 1'b0;
      o_wdt_restart <= 1'b0;
      o_break       <= 1'b0;
    end
    else
    begin
      o_instr_done  <= 1'b0;
      o_dm_we       <= 1'b0;
      o_pm_we       <= 1'b0;
      o_sleep       <= 1'b0;
      o_wdt_restart <= 1'b0;
      o_break       <= 1'b0;
      case (state)
        bftie_pkg::ST_IDLE:
        begin
          o_dm_re <= 1'b0;
          if (accept)
          begin
            o_instr_done <= bftie_pkg::is_single(i_instr_op);  // [RQ18]
            case (i_instr_op)
              bftie_pkg::OP_LOAD, bftie_pkg::OP_POP:
              begin
                o_dm_addr <= agu_bus.eff_addr;                 // [RQ5] [RQ6] [RQ7] [RQ8]
                o_dm_re   <= 1'b1;
                ld_dst    <= i_instr_rd;
                state     <= bftie_pkg::ST_MEM;
              end
              bftie_pkg::OP_STORE, bftie_pkg::OP_PUSH:
              begin
                o_dm_addr  <= agu_bus.eff_addr;                // [RQ9] [RQ10] [RQ11] [RQ12]
                o_dm_wdata <= gpr[i_instr_rr];
                o_dm_we    <= 1'b1;                            // [RQ14]
                state      <= bftie_pkg::ST_MEM;
              end
              bftie_pkg::OP_PM_READ, bftie_pkg::OP_PM_READ_R0:
              begin
                o_pm_addr <= agu_bus.ptr;
                o_pm_re   <= 1'b1;
                ld_dst    <= (i_instr_op == bftie_pkg::OP_PM_READ_R0) ? 5'h00 : i_instr_rd;
                state     <= bftie_pkg::ST_PM_WAIT;
              end
              bftie_pkg::OP_PM_WRITE:
              begin
                o_pm_addr  <= agu_bus.ptr;                     // [RQ19]
                o_pm_wdata <= {gpr[1], gpr[0]};
                o_pm_we    <= 1'b1;
                state      <= bftie_pkg::ST_PM_WRITE;
              end
              bftie_pkg::OP_SLEEP: o_sleep       <= 1'b1;      // [RQ16]
              bftie_pkg::OP_WDR:   o_wdt_restart <= 1'b1;      // [RQ17]
              bftie_pkg::OP_BREAK: o_break       <= i_debug_en; // [RQ20]
              default:
              begin
              end
            endcase
          end
        end
        bftie_pkg::ST_MEM:
        begin
          o_dm_re      <= 1'b0;
          o_instr_done <= 1'b1;
          state        <= bftie_pkg::ST_IDLE;
        end
        bftie_pkg::ST_PM_WAIT: state <= bftie_pkg::ST_PM_DATA;
        bftie_pkg::ST_PM_DATA:
        begin
          o_pm_re      <= 1'b0;
          o_instr_done <= 1'b1;
          state        <= bftie_pkg::ST_IDLE;
        end
        // write duration belongs to the program memory; we just wait for it
        bftie_pkg::ST_PM_WRITE:
        begin
          if (i_pm_wr_done)
          begin
            o_instr_done <= 1'b1;
            state        <= bftie_pkg::ST_IDLE;
          end
        end
        default: state <= bftie_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_flag_set_one: assert property ( // [RQ1]
    accept && i_instr_op == bftie_pkg::OP_FLAG_SET |=>
      o_instr_done && o_flags == ($past(o_flags) | (8'h01 << $past(i_instr_bit))))
    else $error("flag set changed wrong bits");
  a_flag_clr_zero: assert property ( // [RQ2]
    accept && i_instr_op == bftie_pkg::OP_FLAG_CLR |=>
      o_instr_done && o_flags == ($past(o_flags) & ~(8'h01 << $past(i_instr_bit))))
    else $error("flag clear changed wrong bits");
  a_bit_to_flag: assert property ( // [RQ3]
    accept && i_instr_op == bftie_pkg::OP_BIT_TO_FLAG |=>
      o_flags[bftie_pkg::FLAG_T] == $past(src_bit) && o_flags[5:0] == $past(o_flags[5:0]))
    else $error("transfer flag copy wrong");
  a_flag_to_bit: assert property ( // [RQ4]
    accept && i_instr_op == bftie_pkg::OP_FLAG_TO_BIT |=> o_instr_done && $stable(o_flags))
    else $error("bit load disturbed flags");
  a_mem_two_cyc: assert property ( // [RQ8] [RQ11] [RQ12] [RQ14] [RQ15]
    accept && !bftie_pkg::is_single(i_instr_op) && !pm_op |=>
      !o_instr_done && $stable(o_flags) ##1 o_instr_done && $stable(o_flags))
    else $error("memory access not two cycles");
  a_predec_store: assert property ( // [RQ10]
    accept && i_instr_op == bftie_pkg::OP_STORE && i_instr_mode == bftie_pkg::AM_PRE_DEC |=>
      o_dm_we && o_dm_addr == $past(agu_bus.ptr) - 16'h0001)
    else $error("pre-decrement store address wrong");
  a_postinc_load: assert property ( // [RQ5]
    accept && i_instr_op == bftie_pkg::OP_LOAD && i_instr_mode == bftie_pkg::AM_POST_INC |=>
      o_dm_re && o_dm_addr == $past(agu_bus.ptr))
    else $error("post-increment load address wrong");
  a_pm_three_cyc: assert property ( // [RQ13]
    accept && i_instr_op inside {bftie_pkg::OP_PM_READ, bftie_pkg::OP_PM_READ_R0} |=>
      !o_instr_done [*2] ##1 o_instr_done)
    else $error("program read not three cycles");
  a_sleep_pulse: assert property ( // [RQ16]
    accept && i_instr_op == bftie_pkg::OP_SLEEP |=> o_sleep && o_instr_done && $stable(o_flags))
    else $error("sleep not issued in one cycle");
  a_break_gated: assert property ( // [RQ20]
    o_break |-> $past(i_debug_en) && $past(i_instr_op) == bftie_pkg::OP_BREAK)
    else $error("break without debug");

endmodule : bftie_core

//--- bftie_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// data, stack and program memory facing the core
// ----------------------------------------------------------------
module bftie_mem_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_dm_addr,
  input  wire logic [7:0]  i_dm_wdata,
  input  wire logic        i_dm_we,
  input  wire logic        i_dm_re,
  output logic      [7:0]  o_dm_rdata,
  input  wire logic [15:0] i_pm_addr,
  input  wire logic        i_pm_re,
  output logic      [7:0]  o_pm_rdata,
  input  wire logic        i_pm_we,
  input  wire logic [15:0] i_pm_wdata,
  output logic             o_pm_done,
  output logic      [15:0] o_pm_word
);
  logic [7:0] mem [0:255];
  logic [7:0] dm_byte;
  logic [7:0] pm_byte;

  // only the low address byte decodes, so the stack top aliases 0xff
  assign dm_byte    = mem[i_dm_addr[7:0]];
  assign pm_byte    = i_pm_addr[7:0] ^ 8'ha5;
  // an idle port shows the inverse so a capture in the wrong cycle fails
  assign o_dm_rdata = i_dm_re ? dm_byte : ~dm_byte;
  assign o_pm_rdata = i_pm_re ? pm_byte : ~pm_byte;

  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
  end

  // a program write finishes one cycle after its strobe
  always @(posedge i_clk)
  begin
    if (i_dm_we) mem[i_dm_addr[7:0]] <= i_dm_wdata;
    o_pm_done <= i_pm_we;
    if (i_pm_we) o_pm_word <= i_pm_wdata;
  end
endmodule : bftie_mem_model

//--- bit_flag_transfer_instr_exec_test.sv
`timescale 1ns/10ps
module bit_flag_transfer_instr_exec_test;
  typedef struct packed {
    logic [7:0]  op, rd, rr;
    logic [3:0]  md, pt, bt, cy;
    logic [15:0] im;
    logic [7:0]  ck, val, fl;
  } bftie_row_t;
  logic        i_clk = 1'b0, i_nrst = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic        i_instr_valid = 1'b0, i_debug_en = 1'b0, o_wb_ack, o_instr_ready, o_instr_done;
  logic        o_dm_we, o_dm_re, o_pm_re, o_pm_we, i_pm_wr_done, o_io_we, o_io_re;
  logic        o_sleep, o_wdt_restart, o_break;
  logic [1:0]  i_instr_ptr = 2'h0;
  logic [2:0]  i_instr_bit = 3'h0, pulse;
  logic [3:0]  i_wb_sel = 4'hf;
  logic [4:0]  i_instr_rd = 5'h00, i_instr_rr = 5'h00;
  logic [5:0]  o_io_addr;
  logic [7:0]  i_wb_adr = 8'h00, i_io_rdata = 8'h77, o_dm_wdata, i_dm_rdata, i_pm_rdata;
  logic [7:0]  o_io_wdata, o_flags;
  logic [15:0] io;
  logic [15:0] i_instr_imm = 16'h0000, o_dm_addr, o_pm_addr, o_pm_wdata, pm_word;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q;
  bftie_pkg::bftie_op_t    i_instr_op = bftie_pkg::OP_NOP;
  bftie_pkg::bftie_amode_t i_instr_mode = bftie_pkg::AM_PLAIN;
  int          mismatches = 0, samples_checked = 0, cycles = 0, ncyc = 0;
  // ----------------------------------------------------------------
  // op rd rr mode ptr bit cycles imm | reg checked, its value, flags
  // ----------------------------------------------------------------
  bftie_row_t rows [0:41] = '{
    80'h01_00_00_0_0_0_1_0000_00_34_01, 80'h01_00_00_0_0_1_1_0000_00_34_03,
    80'h01_00_00_0_0_2_1_0000_00_34_07, 80'h01_00_00_0_0_3_1_0000_00_34_0f,
    80'h01_00_00_0_0_4_1_0000_00_34_1f, 80'h01_00_00_0_0_5_1_0000_00_34_3f,
    80'h01_00_00_0_0_6_1_0000_00_34_7f, 80'h01_00_00_0_0_7_1_0000_00_34_ff,
    80'h02_00_00_0_0_0_1_0000_00_34_fe, 80'h02_00_00_0_0_1_1_0000_00_34_fc,
    80'h02_00_00_0_0_2_1_0000_00_34_f8, 80'h02_00_00_0_0_3_1_0000_00_34_f0,
    80'h02_00_00_0_0_4_1_0000_00_34_e0, 80'h02_00_00_0_0_5_1_0000_00_34_c0,
    80'h02_00_00_0_0_6_1_0000_00_34_80, 80'h02_00_00_0_0_7_1_0000_00_34_00,
    80'h03_00_0a_0_0_2_1_0000_0a_04_40, 80'h04_0b_00_0_0_7_1_0000_0b_80_40,
    80'h0b_05_00_1_0_0_2_0000_05_2c_40, 80'h00_00_00_0_0_0_1_0000_1a_11_40,
    80'h0c_00_05_2_1_0_2_0000_1c_1f_40, 80'h0b_06_00_4_0_0_2_001f_06_2c_40,
    80'h0b_07_00_3_2_0_2_0003_07_0f_40, 80'h0d_08_00_1_2_0_3_0000_08_95_40,
    80'h08_08_00_0_0_0_1_0000_08_59_40, 80'h00_00_00_0_0_0_1_0000_1e_31_40,
    80'h10_00_08_0_0_0_2_0000_08_59_40, 80'h11_09_00_0_0_0_2_0000_09_59_40,
    80'h05_0c_09_0_0_0_1_0000_0c_59_40, 80'h07_0d_00_0_0_0_1_00a7_0d_a7_40,
    80'h06_0e_00_0_0_0_1_0000_0f_12_40, 80'h09_10_00_0_0_0_1_0005_10_77_40,
    80'h0a_00_0d_0_0_0_1_0005_0d_a7_40, 80'h0e_00_00_0_2_0_3_0000_00_94_40,
    80'h12_00_00_0_0_0_1_0000_00_94_40, 80'h13_00_00_0_0_0_1_0000_00_94_40,
    80'h14_00_00_0_0_0_1_0000_00_94_40, 80'h0f_00_00_0_2_0_3_0000_00_94_40,
    80'h0c_00_0d_1_0_0_2_0000_1a_12_40, 80'h0c_00_0c_3_1_0_2_0002_1c_1f_40,
    80'h0c_00_0d_4_0_0_2_0022_0d_a7_40, 80'h0b_11_00_2_2_0_2_0000_11_0c_40};

  bftie_core dut_u (.*);
  bftie_mem_model mem_u (.i_clk(i_clk), .i_dm_addr(o_dm_addr), .i_dm_wdata(o_dm_wdata),
    .i_dm_we(o_dm_we), .i_dm_re(o_dm_re), .o_dm_rdata(i_dm_rdata), .i_pm_addr(o_pm_addr),
    .i_pm_re(o_pm_re), .o_pm_rdata(i_pm_rdata), .i_pm_we(o_pm_we), .i_pm_wdata(o_pm_wdata),
    .o_pm_done(i_pm_wr_done), .o_pm_word(pm_word));

  always #5 i_clk = ~i_clk;

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // a hang ends the run as a mismatch
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    @(posedge i_clk);
    while (o_wb_ack !== 1'b1) @(posedge i_clk);
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask : wb

  task automatic exec(input bftie_row_t r);
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr_op    <= bftie_pkg::bftie_op_t'(r.op[4:0]);
    i_instr_mode  <= bftie_pkg::bftie_amode_t'(r.md[2:0]);
    i_instr_ptr   <= r.pt[1:0];
    i_instr_rd    <= r.rd[4:0];
    i_instr_rr    <= r.rr[4:0];
    i_instr_bit   <= r.bt[2:0];
    i_instr_imm   <= r.im;
    @(negedge i_clk);
    while (o_instr_ready !== 1'b1) @(negedge i_clk);
    io = {o_io_re, o_io_we, o_io_addr, o_io_wdata};
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    ncyc = 1;
    @(negedge i_clk);
    while (o_instr_done !== 1'b1)
    begin
      @(negedge i_clk);
      ncyc++;
    end
    pulse = {o_sleep, o_wdt_restart, o_break};
  endtask : exec

  initial
  begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(negedge i_clk);
    chk("ready before run", 32'h0, 32'(o_instr_ready));
    chk("flags at reset", 32'h0, 32'(o_flags));
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, q);
    wb(1'b1, bftie_pkg::ADR_CTRL, 32'h1);
    wb(1'b1, 8'h80, 32'h34);
    wb(1'b1, 8'h84, 32'h12);
    wb(1'b1, 8'ha8, 32'h04);
    wb(1'b1, 8'he8, 32'h10);
    wb(1'b1, 8'hf0, 32'h20);
    wb(1'b1, 8'hf8, 32'h30);
    foreach (rows[i])
    begin
      exec(rows[i]);
      if (rows[i].cy != 4'h0) chk("cycles", 32'(rows[i].cy), ncyc);
      chk("flags", 32'(rows[i].fl), 32'(o_flags));
      wb(1'b0, {1'b1, rows[i].ck[4:0], 2'b00}, 32'h0);
      chk("register", 32'(rows[i].val), q);
      chk("pulses", 32'({rows[i].op == 8'h12, rows[i].op == 8'h13, 1'b0}), 32'(pulse));
      if (rows[i].op == 8'h0a) chk("port write", 32'({2'b01, rows[i].im[5:0], rows[i].val}), 32'(io));
      if (rows[i].op == 8'h09) chk("port read", 32'({2'b10, rows[i].im[5:0]}), 32'(io[15:8]));
    end
    chk("program word", 32'h1294, 32'(pm_word));
    chk("stored bytes", 32'ha759a7, 32'({mem_u.mem[8'h11], mem_u.mem[8'h21], mem_u.mem[8'h22]}));
    wb(1'b0, bftie_pkg::ADR_SP, 32'h0);
    chk("stack pointer", 32'h1ff, q);
    i_debug_en <= 1'b1;
    exec(80'h14_00_00_0_0_0_1_0000_00_94_40);
    chk("break pulse", 32'h1, 32'(pulse));
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(negedge i_clk);
    chk("flags after reset", 32'h0, 32'(o_flags));
    chk("ready after reset", 32'h0, 32'(o_instr_ready));
    end_of_test();
  end
endmodule : bit_flag_transfer_instr_exec_test
